// File: include/jks_pkg.sv
// Purpose: shared constants for the J-K state sequencer core
// Assumes: word-addressed programming port, 32-bit data
// Notes: fuse words per product term are laid out at term*4 + field
package jks_pkg;
    localparam int NUM_TERMS = 48;
    localparam int NUM_INPUTS = 16;
    localparam int STATE_W = 6;
    localparam int OUT_W = 8;
    localparam int FF_W = STATE_W + OUT_W;
    // product-term variables: {complement_feedback, state, inputs}
    localparam int VAR_W = NUM_INPUTS + STATE_W + 1;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // fuse word fields inside one term slot
    localparam logic [1:0] FLD_TRUE = 2'h0;
    localparam logic [1:0] FLD_COMP = 2'h1;
    localparam logic [1:0] FLD_JCON = 2'h2;
    localparam logic [1:0] FLD_KCON = 2'h3;
    localparam int TERM_EN_BIT = 31;
    localparam int CA_CONN_BIT = 31;
    // configuration and status words above the term area
    localparam logic [ADDR_W-1:0] ADDR_CFG = 8'hc0;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'hc1;
    localparam int CFG_OUTEN_BIT = 0;
    localparam int CFG_LOCK_BIT = 1;
    localparam int STAT_OUT_LSB = 8;
    localparam int STAT_LOCK_BIT = 16;
    localparam int STAT_OUTEN_BIT = 17;
    // reset values: registers power up to all ones, fuses blank
    localparam logic [STATE_W-1:0] STATE_RST = 6'h3f;
    localparam logic [OUT_W-1:0] OUT_RST = 8'hff;
    localparam logic [VAR_W-1:0] MASK_RST = 23'h0;
    localparam logic [FF_W-1:0] CONN_RST = 14'h0;
    localparam logic OUTEN_SEL_RST = 1'b0;
    // clocks to skip after preset release before clocking resumes
    localparam int PRESET_LOCKOUT_CYC = 1;
endpackage

// File: rtl/jks_jk_reg.sv
// Purpose: bank of rising-edge J-K flip-flops with direct load
// Assumes: preset and load are sampled synchronously
// Notes: preset wins over load, load wins over J-K excitation
`timescale 1ns/1ps
module jks_jk_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic i_preset,
    input wire logic i_upd_en,
    input wire logic i_load,
    input wire logic [W-1:0] i_load_val,
    input wire logic [W-1:0] i_j,
    input wire logic [W-1:0] i_k,
    output logic [W-1:0] o_q
);
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // j-k table: 00 hold, 01 clear, 10 set, 11 hold
    always_comb begin
        nxt_q = q_ff;
        for (int b = 0; b < W; b++) begin
            if (i_j[b] && !i_k[b]) begin
                nxt_q[b] = 1'b1; // [RULE_13]
            end else if (!i_j[b] && i_k[b]) begin
                nxt_q[b] = 1'b0; // [RULE_13]
            end
        end
    end

    // power-up value is all ones, not the port levels
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin // [RULE_01]
        if (!i_arst_n) begin
            q_ff <= RST_VAL; // [RULE_02]
        end else if (i_clk_en) begin
            if (i_preset) begin
                q_ff <= RST_VAL; // [RULE_18]
            end else if (i_upd_en && i_load) begin
                q_ff <= i_load_val;
            end else if (i_upd_en) begin
                q_ff <= nxt_q;
            end
        end
    end

    assign o_q = q_ff;
endmodule

// File: rtl/jks_term_array.sv
// Purpose: programmable and-array with complement feedback
// Assumes: terms wired into the complement array do not use its output
// Notes: purely combinational; fuses arrive from the core's arrays
`timescale 1ns/1ps
module jks_term_array
    import jks_pkg::*;
(
    input wire logic [NUM_INPUTS-1:0] i_logic_in,
    input wire logic [STATE_W-1:0] i_state,
    input wire logic [VAR_W-1:0] i_true_en [NUM_TERMS],
    input wire logic [VAR_W-1:0] i_comp_en [NUM_TERMS],
    input wire logic [NUM_TERMS-1:0] i_term_en,
    input wire logic [NUM_TERMS-1:0] i_ca_conn,
    input wire logic [FF_W-1:0] i_j_conn [NUM_TERMS],
    input wire logic [FF_W-1:0] i_k_conn [NUM_TERMS],
    output logic o_complement_feedback,
    output logic [FF_W-1:0] o_j,
    output logic [FF_W-1:0] o_k
);
    logic [VAR_W-2:0] base_vars;
    logic [NUM_TERMS-1:0] pre_terms;
    logic [NUM_TERMS-1:0] terms;

    // one product term; a disabled term is always low
    function automatic logic eval_term(input logic [VAR_W-1:0] v,
                                       input logic [VAR_W-1:0] t_en,
                                       input logic [VAR_W-1:0] c_en,
                                       input logic en);
        eval_term = en && (&(v | ~t_en)) && (&(~v | ~c_en)); // [RULE_05]
    endfunction

    assign base_vars = {i_state, i_logic_in};

    // first pass ignores the feedback literal, breaking the loop
    always_comb begin
        for (int t = 0; t < NUM_TERMS; t++) begin
            pre_terms[t] = eval_term({1'b1, base_vars},
                                     {1'b0, i_true_en[t][VAR_W-2:0]},
                                     {1'b0, i_comp_en[t][VAR_W-2:0]},
                                     i_term_en[t]);
        end
    end

    // nor of the connected terms: low if any is active
    assign o_complement_feedback = ~|(pre_terms & i_ca_conn); // [RULE_09]

    always_comb begin
        for (int t = 0; t < NUM_TERMS; t++) begin
            terms[t] = eval_term({o_complement_feedback, base_vars},
                                 i_true_en[t], i_comp_en[t],
                                 i_term_en[t]); // [RULE_10] [RULE_11]
        end
    end

    // or-array: unconnected flip-flop inputs stay low
    always_comb begin
        o_j = '0;
        o_k = '0;
        for (int t = 0; t < NUM_TERMS; t++) begin
            if (terms[t]) begin
                o_j = o_j | i_j_conn[t]; // [RULE_06]
                o_k = o_k | i_k_conn[t]; // [RULE_06]
            end
        end
    end
endmodule

// File: rtl/jks_sequencer_core.sv
// Purpose: registered core of a programmable logic sequencer
// Assumes: all pins synchronous to i_core_clk; over-voltage detection
//   of the three diagnostic inputs is done outside and given as levels
// Notes: pin drive is registered, so pins follow registers one clock late
// Behaviour
// (RULE_01) registers change only on a rising clock edge
// (RULE_02) power-up sets every state and output register bit to one
// (RULE_03) shared pin is preset or active-low enable, never both
// (RULE_04) unprogrammed option makes the shared pin a preset
// (RULE_05) unprogrammed transition terms evaluate to zero
// (RULE_06) unprogrammed flip-flop excitation inputs are held at zero
// (RULE_07) diagnostic loads put the used output pins in high impedance
// (RULE_08) outside party drives load values on pins before the edge
// (RULE_09) complement array ors selected terms, inverts, feeds back
// (RULE_10) feedback is low when any connected term is active
// (RULE_11) feedback is high when all connected terms are inactive
// (RULE_12) designers should use feedback to recover from illegal states
// (RULE_13) j-k: 00 hold, 01 clear, 10 set, 11 hold
// (RULE_14) enable high gives high-impedance pins, registers keep value; here the registers keep clocking while the pins float
// (RULE_15) observe mode shows state bits on pins 0-5, outputs unchanged
// (RULE_16) state load mode clocks pins 0-5 into state register
// (RULE_17) output load mode clocks pins 0-7 into output register
// (RULE_18) preset sets all bits, drives outputs high, blocks clocking
`timescale 1ns/1ps
module jks_sequencer_core
    import jks_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic [NUM_INPUTS-1:0] i_logic_in,
    input wire logic i_diag_load_outreg_input,
    input wire logic i_diag_load_statereg_input,
    input wire logic i_diag_observe_state_input,
    input wire logic i_preset_or_outen_pin,
    input wire logic [OUT_W-1:0] i_output_pins_in,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [OUT_W-1:0] o_output_pins_out,
    output logic [OUT_W-1:0] o_output_pins_oe,
    output logic [DATA_W-1:0] o_rdata
);
    typedef enum logic [2:0] {
        PS_RUN = 3'b001,
        PS_HOLD = 3'b010,
        PS_LOCK = 3'b100
    } jks_pst_type;

    // fuse store: one slot per product term
    logic [VAR_W-1:0] true_en_ff [NUM_TERMS];
    logic [VAR_W-1:0] comp_en_ff [NUM_TERMS];
    logic [FF_W-1:0] j_conn_ff [NUM_TERMS];
    logic [FF_W-1:0] k_conn_ff [NUM_TERMS];
    logic [NUM_TERMS-1:0] term_en_ff;
    logic [NUM_TERMS-1:0] ca_conn_ff;
    logic outen_sel_ff;
    logic cfg_lock_ff;
    jks_pst_type pst_ff;
    jks_pst_type nxt_pst;
    logic [$clog2(PRESET_LOCKOUT_CYC+1)-1:0] lock_cnt_ff;
    logic [OUT_W-1:0] pin_out_ff;
    logic [OUT_W-1:0] pin_oe_ff;
    logic [DATA_W-1:0] rdata_ff;

    logic [STATE_W-1:0] state_q;
    logic [OUT_W-1:0] out_q;
    logic [FF_W-1:0] j_all;
    logic [FF_W-1:0] k_all;
    logic c0;
    logic preset_act;
    logic outen_off;
    logic upd_en;
    logic [5:0] wr_term;
    logic wr_term_ok;

    // decode a term slot from a word address
    function automatic logic term_hit(input logic [ADDR_W-1:0] a);
        term_hit = (int'(a[ADDR_W-1:2]) < NUM_TERMS);
    endfunction

    assign wr_term = i_addr[ADDR_W-1:2];
    assign wr_term_ok = i_wr && term_hit(i_addr);

    // the option bit makes the pin one function only
    assign preset_act = !outen_sel_ff && i_preset_or_outen_pin; // [RULE_03]
    assign outen_off = outen_sel_ff && i_preset_or_outen_pin; // [RULE_03]
    // clocking blocked while preset holds and for the lockout edge
    assign upd_en = (pst_ff == PS_RUN) && !preset_act; // [RULE_18]

    jks_term_array u_terms (
        .i_logic_in(i_logic_in),
        .i_state(state_q),
        .i_true_en(true_en_ff),
        .i_comp_en(comp_en_ff),
        .i_term_en(term_en_ff),
        .i_ca_conn(ca_conn_ff),
        .i_j_conn(j_conn_ff),
        .i_k_conn(k_conn_ff),
        .o_complement_feedback(c0),
        .o_j(j_all),
        .o_k(k_all)
    );

    // state register: diagnostic state load wins only when not
    // loading the output register, so the modes stay exclusive
    jks_jk_reg #(
        .W(STATE_W),
        .RST_VAL(STATE_RST)
    ) u_state (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_clk_en(i_clk_en),
        .i_preset(preset_act),
        .i_upd_en(upd_en && !i_diag_load_outreg_input),
        .i_load(i_diag_load_statereg_input), // [RULE_16]
        .i_load_val(i_output_pins_in[STATE_W-1:0]), // [RULE_08]
        .i_j(j_all[STATE_W-1:0]),
        .i_k(k_all[STATE_W-1:0]),
        .o_q(state_q)
    );

    // output register frozen during state load and observe modes
    jks_jk_reg #(
        .W(OUT_W),
        .RST_VAL(OUT_RST)
    ) u_out (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_clk_en(i_clk_en),
        .i_preset(preset_act),
        .i_upd_en(upd_en && (i_diag_load_outreg_input
                  || !(i_diag_load_statereg_input
                  || i_diag_observe_state_input))), // [RULE_15] [RULE_16]
        .i_load(i_diag_load_outreg_input), // [RULE_17]
        .i_load_val(i_output_pins_in),
        .i_j(j_all[FF_W-1:STATE_W]),
        .i_k(k_all[FF_W-1:STATE_W]),
        .o_q(out_q)
    );

    // preset release: skip a full clock before normal updates resume
    always_comb begin
        nxt_pst = pst_ff;
        case (pst_ff)
            PS_RUN: begin
                if (preset_act) begin
                    nxt_pst = PS_HOLD;
                end
            end
            PS_HOLD: begin
                // the release edge is itself the first locked-out edge
                if (!preset_act && PRESET_LOCKOUT_CYC > 1) begin
                    nxt_pst = PS_LOCK; // [RULE_18]
                end else if (!preset_act) begin
                    nxt_pst = PS_RUN; // [RULE_18]
                end
            end
            PS_LOCK: begin
                if (preset_act) begin
                    nxt_pst = PS_HOLD;
                end else if (int'(lock_cnt_ff) >= PRESET_LOCKOUT_CYC - 2) begin
                    nxt_pst = PS_RUN;
                end
            end
            default: begin
                nxt_pst = PS_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pst_ff <= PS_RUN;
        end else if (i_clk_en) begin
            pst_ff <= nxt_pst;
        end
    end

    // lockout counter, cleared whenever the state is not PS_LOCK
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lock_cnt_ff <= '0;
        end else if (i_clk_en) begin
            if (pst_ff != PS_LOCK) begin
                lock_cnt_ff <= '0;
            end else begin
                lock_cnt_ff <= lock_cnt_ff + 1'b1;
            end
        end
    end

    // option is one-time: a write that sets the lock bit locks it, like a blown fuse
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            outen_sel_ff <= OUTEN_SEL_RST; // [RULE_04]
            cfg_lock_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (i_wr && i_addr == ADDR_CFG && !cfg_lock_ff) begin
                outen_sel_ff <= i_wdata[CFG_OUTEN_BIT];
                cfg_lock_ff <= i_wdata[CFG_LOCK_BIT];
            end
        end
    end

    // term enable and complement connection bits, reset to blank
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            term_en_ff <= '0; // [RULE_05]
            ca_conn_ff <= '0;
        end else if (i_clk_en && wr_term_ok) begin
            if (i_addr[1:0] == FLD_TRUE) begin
                term_en_ff[wr_term] <= i_wdata[TERM_EN_BIT];
            end
            if (i_addr[1:0] == FLD_COMP) begin
                ca_conn_ff[wr_term] <= i_wdata[CA_CONN_BIT];
            end
        end
    end

    // literal and connection fuses, reset to blank
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int t = 0; t < NUM_TERMS; t++) begin
                true_en_ff[t] <= MASK_RST;
                comp_en_ff[t] <= MASK_RST;
                j_conn_ff[t] <= CONN_RST; // [RULE_06]
                k_conn_ff[t] <= CONN_RST; // [RULE_06]
            end
        end else if (i_clk_en && wr_term_ok) begin
            case (i_addr[1:0])
                FLD_TRUE: true_en_ff[wr_term] <= i_wdata[VAR_W-1:0];
                FLD_COMP: comp_en_ff[wr_term] <= i_wdata[VAR_W-1:0];
                FLD_JCON: j_conn_ff[wr_term] <= i_wdata[FF_W-1:0];
                FLD_KCON: k_conn_ff[wr_term] <= i_wdata[FF_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // pin drive, registered: each mode picks data and enables
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_out_ff <= OUT_RST;
            pin_oe_ff <= '1;
        end else if (i_clk_en) begin
            pin_out_ff <= out_q;
            pin_oe_ff <= '1;
            if (preset_act) begin
                pin_out_ff <= OUT_RST; // [RULE_18]
            end else if (i_diag_load_outreg_input) begin
                pin_oe_ff <= '0; // [RULE_07]
            end else if (i_diag_load_statereg_input) begin
                pin_oe_ff[STATE_W-1:0] <= '0; // [RULE_07]
            end else if (i_diag_observe_state_input) begin
                pin_out_ff[STATE_W-1:0] <= state_q; // [RULE_15]
            end
            if (outen_off) begin
                pin_oe_ff <= '0; // [RULE_14]
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_ff <= '0;
        end else if (i_clk_en) begin
            rdata_ff <= '0;
            if (i_rd && term_hit(i_addr)) begin
                case (i_addr[1:0])
                    FLD_TRUE: rdata_ff <= DATA_W'({term_en_ff[i_addr[7:2]],
                        8'h0, true_en_ff[i_addr[7:2]]});
                    FLD_COMP: rdata_ff <= DATA_W'({ca_conn_ff[i_addr[7:2]],
                        8'h0, comp_en_ff[i_addr[7:2]]});
                    FLD_JCON: rdata_ff <= DATA_W'(j_conn_ff[i_addr[7:2]]);
                    default: rdata_ff <= DATA_W'(k_conn_ff[i_addr[7:2]]);
                endcase
            end else if (i_rd && i_addr == ADDR_CFG) begin
                rdata_ff[CFG_OUTEN_BIT] <= outen_sel_ff;
                rdata_ff[CFG_LOCK_BIT] <= cfg_lock_ff;
            end else if (i_rd && i_addr == ADDR_STAT) begin
                rdata_ff[STATE_W-1:0] <= state_q;
                rdata_ff[STAT_OUT_LSB+OUT_W-1:STAT_OUT_LSB] <= out_q;
                rdata_ff[STAT_LOCK_BIT] <= cfg_lock_ff;
                rdata_ff[STAT_OUTEN_BIT] <= c0;
            end
        end
    end

    assign o_output_pins_out = pin_out_ff;
    assign o_output_pins_oe = pin_oe_ff;
    assign o_rdata = rdata_ff;
endmodule

// File: verif/jks_sequencer_core_assertions.sv
// Purpose: port checks for the J-K sequencer core
// Assumes: pins lag registers and mode inputs by one clock
// Notes: fuse contents are invisible here, only pin behaviour is judged
`timescale 1ns/1ps
module jks_core_checker
    import jks_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic [NUM_INPUTS-1:0] i_logic_in,
    input wire logic i_diag_load_outreg_input,
    input wire logic i_diag_load_statereg_input,
    input wire logic i_diag_observe_state_input,
    input wire logic i_preset_or_outen_pin,
    input wire logic [OUT_W-1:0] i_output_pins_in,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [OUT_W-1:0] o_output_pins_out,
    input wire logic [OUT_W-1:0] o_output_pins_oe,
    input wire logic [DATA_W-1:0] o_rdata
);
    logic quiet;
    logic no_diag;
    logic ld_o;
    logic ld_s;
    // clocking allowed and shared pin low, so no preset takes part
    assign quiet = i_clk_en && !i_preset_or_outen_pin;
    assign ld_o = i_diag_load_outreg_input;
    assign ld_s = i_diag_load_statereg_input && !ld_o;
    assign no_diag = !(ld_o || ld_s || i_diag_observe_state_input);

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    // a quiet edge first keeps the load clear of the preset lockout
    sequence s_out_load;
        quiet ##1 (quiet && ld_o);
    endsequence
    sequence s_state_load;
        quiet ##1 (quiet && ld_s);
    endsequence

    a_reset_pins_high: assert property ($rose(i_arst_n) |->
        o_output_pins_out == 8'hff && o_output_pins_oe == 8'hff)
        else $error("pins not high after power-up");
    a_freeze_no_clk: assert property (!i_clk_en |=>
        $stable(o_output_pins_out) && $stable(o_output_pins_oe))
        else $error("pins moved without a clock");
    a_preset_or_hiz: assert property (
        i_preset_or_outen_pin && i_clk_en |=>
        o_output_pins_out == 8'hff || o_output_pins_oe == 8'h00)
        else $error("shared pin neither preset nor disable");
    a_load_out_hiz: assert property (quiet && ld_o |=>
        o_output_pins_oe == 8'h00)
        else $error("pins driven in output load");
    a_load_st_hiz: assert property (quiet && ld_s |=>
        o_output_pins_oe[5:0] == 6'h00)
        else $error("pins driven in state load");
    a_out_load_lands: assert property (
        s_out_load ##1 (quiet && no_diag) |=>
        o_output_pins_out == $past(i_output_pins_in, 2)
        && o_output_pins_oe == 8'hff)
        else $error("output load not shown on pins");
    a_state_observed: assert property (
        s_state_load ##1 (quiet && i_diag_observe_state_input && !ld_o
        && !i_diag_load_statereg_input) |=>
        o_output_pins_out[5:0] == $past(i_output_pins_in[5:0], 2))
        else $error("state load not observed on pins");
    a_idle_drive: assert property (quiet && no_diag |=>
        o_output_pins_oe == 8'hff)
        else $error("pins not driven in normal mode");
endmodule

bind jks_sequencer_core jks_core_checker u_chk (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_logic_in(i_logic_in),
    .i_diag_load_outreg_input(i_diag_load_outreg_input),
    .i_diag_load_statereg_input(i_diag_load_statereg_input),
    .i_diag_observe_state_input(i_diag_observe_state_input),
    .i_preset_or_outen_pin(i_preset_or_outen_pin),
    .i_output_pins_in(i_output_pins_in), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_output_pins_out(o_output_pins_out),
    .o_output_pins_oe(o_output_pins_oe), .o_rdata(o_rdata)
);

// File: verif/jks_board_model.sv
// Purpose: board side of the output pins during diagnostic loads
// Assumes: no pull resistors on the pins
// Notes: contention is resolved in favour of the core, not modelled
`timescale 1ns/1ps
module jks_board_model
    import jks_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic [OUT_W-1:0] i_pins_out,
    input wire logic [OUT_W-1:0] i_pins_oe,
    input wire logic i_drive_en,
    input wire logic [OUT_W-1:0] i_drive_val,
    output logic [OUT_W-1:0] o_pins_level
);
    logic [OUT_W-1:0] last_level_ff;
    // a floating pin flips each cycle so a stale value never passes
    always_comb begin
        for (int b = 0; b < OUT_W; b++) begin
            if (i_pins_oe[b])
                o_pins_level[b] = i_pins_out[b];
            else if (i_drive_en)
                o_pins_level[b] = i_drive_val[b];
            else
                o_pins_level[b] = ~last_level_ff[b];
        end
    end
    // remembered level for the floating case
    always_ff @(posedge i_core_clk) begin
        last_level_ff <= o_pins_level;
    end
endmodule

// File: verif/test_jks_sequencer_core.sv
// Purpose: self-checking bench for the J-K sequencer core
// Assumes: board model resolves the output pins
// Notes: status is read back to see the buried registers
`timescale 1ns/1ps
module test_jks_sequencer_core
    import jks_pkg::*;
;
    localparam logic [31:0] EN = 32'h1 << TERM_EN_BIT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cke = 1'b1;
    logic [NUM_INPUTS-1:0] lin = '0;
    logic ld_out = 1'b0;
    logic ld_st = 1'b0;
    logic obs = 1'b0;
    logic shr = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic drv_en = 1'b0;
    logic [OUT_W-1:0] drv_val = '0;
    logic [OUT_W-1:0] pin_lvl;
    logic [OUT_W-1:0] p_out;
    logic [OUT_W-1:0] p_oe;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] st;
    int n_mismatch = 0;
    int samples_checked = 0;

    // 125 MHz core clock
    always #4 clk = ~clk;

    jks_sequencer_core dut (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_clk_en(cke),
        .i_logic_in(lin), .i_diag_load_outreg_input(ld_out),
        .i_diag_load_statereg_input(ld_st),
        .i_diag_observe_state_input(obs), .i_preset_or_outen_pin(shr),
        .i_output_pins_in(pin_lvl), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_output_pins_out(p_out),
        .o_output_pins_oe(p_oe), .o_rdata(rdata)
    );
    jks_board_model board (
        .i_core_clk(clk), .i_pins_out(p_out), .i_pins_oe(p_oe),
        .i_drive_en(drv_en), .i_drive_val(drv_val), .o_pins_level(pin_lvl)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_stat();
        addr <= ADDR_STAT;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        #1 st = rdata;
        tick(1);
    endtask
    task automatic term(input int t, input logic [1:0] f,
            input logic [31:0] d);
        wr_reg(ADDR_W'(t * 4) + ADDR_W'(f), d);
    endtask

    task automatic t_reset();
        lin <= 16'ha5c3;
        #1 chk("pins", p_out, 8'hff);
        tick(3);
        cke <= 1'b0;
        lin <= 16'h3c5a;
        tick(3);
        cke <= 1'b1;
        rd_stat();
        chk("state", st[5:0], 6'h3f);
        chk("outreg", st[15:8], 8'hff);
    endtask
    task automatic t_diag();
        drv_en <= 1'b1;
        drv_val <= 8'h5a;
        ld_out <= 1'b1;
        tick(1);
        #1 chk("oe", p_oe, 8'h00);
        tick(1);
        ld_out <= 1'b0;
        drv_en <= 1'b0;
        tick(2);
        #1 chk("pins", p_out, 8'h5a);
        tick(1);
        drv_en <= 1'b1;
        drv_val <= 8'h15;
        ld_st <= 1'b1;
        tick(1);
        #1 chk("oe", p_oe[5:0], 6'h00);
        tick(1);
        ld_st <= 1'b0;
        obs <= 1'b1;
        drv_en <= 1'b0;
        tick(2);
        #1 chk("pins", p_out[5:0], 6'h15);
        tick(1);
        rd_stat();
        chk("outreg", st[15:8], 8'h5a);
        chk("state", st[5:0], 6'h15);
        obs <= 1'b0;
    endtask
    // an always-true term clears state bit 0 once clocking resumes
    task automatic t_preset();
        term(0, FLD_KCON, 32'h1);
        term(0, FLD_TRUE, EN);
        shr <= 1'b1;
        obs <= 1'b1; // pins show state, so the resume edge is visible
        tick(2);
        #1 chk("pins", p_out, 8'hff);
        tick(1);
        rd_stat();
        chk("state", st[5:0], 6'h3f);
        shr <= 1'b0;
        tick(1);
        rd_stat();
        chk("state", st[5:0], 6'h3f);
        #1 chk("pins", p_out[5:0], 6'h3e);
        tick(1);
        rd_stat();
        chk("state", st[5:0], 6'h3e);
        obs <= 1'b0;
    endtask
    // bit0 clear, bit1 set, bits 2 and 3 both inputs high hold
    task automatic t_jk();
        term(0, FLD_TRUE, 32'h0);
        drv_en <= 1'b1;
        drv_val <= 8'h05;
        ld_st <= 1'b1;
        tick(2);
        ld_st <= 1'b0;
        drv_en <= 1'b0;
        term(1, FLD_JCON, 32'h0e);
        term(1, FLD_KCON, 32'h0d);
        term(1, FLD_TRUE, EN);
        rd_stat();
        chk("state", st[5:0], 6'h06);
    endtask
    // term 2 watches input 0; term 3 fires on the feedback alone
    task automatic t_comp();
        lin <= 16'h0001;
        term(2, FLD_COMP, 32'h1 << CA_CONN_BIT);
        term(2, FLD_TRUE, EN | 32'h1);
        term(3, FLD_KCON, 32'h40);
        term(3, FLD_TRUE, EN | 32'h400000); // recovery term
        rd_stat();
        chk("outreg", st[15:8], 8'hff);
        chk("feedback", st[17], 1'b0);
        lin <= 16'h0000;
        tick(2);
        rd_stat();
        chk("outreg", st[15:8], 8'hfe);
        chk("feedback", st[17], 1'b1);
    endtask
    task automatic t_outen();
        wr_reg(ADDR_CFG, 32'h1);
        shr <= 1'b1;
        tick(2);
        #1 chk("oe", p_oe, 8'h00);
        tick(1);
        rd_stat();
        chk("state", st[5:0], 6'h06);
        chk("outreg", st[15:8], 8'hfe);
        shr <= 1'b0;
        wr_reg(ADDR_CFG, 32'h3);
        wr_reg(ADDR_CFG, 32'h0);
        shr <= 1'b1;
        tick(2);
        #1 chk("oe", p_oe, 8'h00);
        tick(1);
        shr <= 1'b0;
        tick(2);
        #1 chk("oe", p_oe, 8'hff);
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        t_reset();
        t_diag();
        t_preset();
        t_jk();
        t_comp();
        t_outen();
        wrap_up();
    end
    // the sequence needs about 95 cycles; this allows 2500, over twenty-five times that
    initial begin
        #20000;
        n_mismatch++;
        wrap_up();
    end
endmodule
